// [design/load_current_trim_ocp_compare.sv]
/*
 * Trim registers, calibration, overcurrent compare and light load
 * detection for two load current sense channels, with an APB slave
 * and a masked interrupt.
 * Assumes converter samples and soft start levels come from logic
 * on pclk, so they are not synchronised.
 * Software keeps thresholds in the valid code span; the
 * compare does not police them.
 * Debounce counts default to real time at 125 MHz; a bench
 * may shrink them through the parameters.
 * Flags and the interrupt are levels from flip-flops.
 */
`timescale 1ns/1ns
`default_nettype none
`include "load_current_trim_params.svh"

module load_current_trim_ocp_compare
    import load_current_trim_pkg::*;
#(
    parameter int unsigned DEB1_CYC = `DEB1_CYC,
    parameter int unsigned DEB2_CYC = `DEB2_CYC,
    parameter int unsigned DEB3_CYC = `DEB3_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Converter samples
    input  wire logic        adc_valid_a,
    input  wire logic [11:0] adc_raw_a,
    input  wire logic        adc_valid_b,
    input  wire logic [11:0] adc_raw_b,
    // Soft start levels
    input  wire logic        soft_start_a,
    input  wire logic        soft_start_b,
    // Flags and front end control
    output logic             chan_a_overcurrent_flag,
    output logic             chan_b_overcurrent_flag,
    output logic             chan_a_light_load_flag,
    output logic             chan_b_light_load_flag,
    output logic             sense_high_side_a,
    output logic             sense_high_side_b,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    // Index 0 is channel A, index 1 channel B
    logic [7:0]  gain_b_r;          // Channel B gain trim
    logic [7:0]  dofs_r [2];        // Digital offset trims
    logic [7:0]  aofs_r [2];        // Analog offset trims
    logic [7:0]  thr_r  [2];        // Overcurrent thresholds
    logic [7:0]  ctrl_r [2];        // Placement and light load
    logic [15:0] value_r [2];       // Sensed current values
    logic [15:0] value_nxt [2];     // Next sensed values
    logic [3:0]  status_r;          // Sticky event bits
    logic [3:0]  mask_r;            // Interrupt enables
    logic [3:0]  flags_prev_r;      // Flags one cycle back
    logic [1:0]  ocp_r;             // Debounced overcurrent
    logic [1:0]  ll_r;              // Light load flags
    logic [31:0] prdata_r;          // Registered read data
    logic        pslverr_r;         // Registered error answer

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [15:0] idx;               // Register index
    logic        addr_ok;           // Aligned, inside index space
    logic        wr_en;             // Write takes effect now
    logic        setup;             // Setup phase of a transfer
    logic [31:0] rd_mux;            // Read value for this index
    logic        hit;               // Index is mapped
    logic [7:0]  wb;                // Low byte of write data
    logic [3:0]  flags_now;         // Current flag vector

    // Word index; low bits and bits above the index space
    // must be zero or the access is refused
    assign idx     = paddr[17:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0000);
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite && !pslverr_r;
    assign wb      = pwdata[7:0];
    // Same layout in the flags, status and mask words
    assign flags_now = {ll_r[1], ll_r[0], ocp_r[1], ocp_r[0]};

    // Zero wait state: data is registered in setup, so the
    // access phase can always answer at once
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // Read multiplexer; narrow registers read zero above
    // hit starts from the address check; unmapped clears it
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = addr_ok;
        case (idx)
            `IDX_GAIN_B:     rd_mux = {24'h000000, gain_b_r};
            `IDX_DOFS_A:     rd_mux = {24'h000000, dofs_r[0]};
            `IDX_DOFS_B:     rd_mux = {24'h000000, dofs_r[1]};
            `IDX_AOFS_A:     rd_mux = {24'h000000, aofs_r[0]};
            `IDX_AOFS_B:     rd_mux = {24'h000000, aofs_r[1]};
            `IDX_THR_A:      rd_mux = {24'h000000, thr_r[0]};
            `IDX_THR_B:      rd_mux = {24'h000000, thr_r[1]};
            `IDX_CTRL_A:     rd_mux = {24'h000000, ctrl_r[0]};
            `IDX_CTRL_B:     rd_mux = {24'h000000, ctrl_r[1]};
            `IDX_VALUE_A:    rd_mux = {16'h0000, value_r[0]};
            `IDX_VALUE_B:    rd_mux = {16'h0000, value_r[1]};
            `IDX_FLAGS:      rd_mux = {28'h0000000, flags_now};
            `IDX_IRQ_STATUS: rd_mux = {28'h0000000, status_r};
            `IDX_IRQ_MASK:   rd_mux = {28'h0000000, mask_r};
            default: begin
                // Unmapped index answers with an error
                hit = 1'b0;
            end
        endcase
    end

    // Read data and error captured in the setup cycle
    // Trade-off: no wait states, but a read shows the
    // register as it stood one cycle before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : (hit ? rd_mux : 32'h0000_0000);
            pslverr_r <= !hit;
        end
    end

    // ------------------------------------------------------------
    // Trim and control registers
    // ------------------------------------------------------------
    // Every bit is read/write, reserved analog bit 7 included
    // A write lands on the access edge, never after an error
    // Thresholds reset to the disabled code so no flag
    // trips before software has set them up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_b_r  <= `RST_TRIM;
            dofs_r[0] <= `RST_TRIM;
            dofs_r[1] <= `RST_TRIM;
            aofs_r[0] <= `RST_TRIM;
            aofs_r[1] <= `RST_TRIM;
            thr_r[0]  <= `RST_THR;
            thr_r[1]  <= `RST_THR;
            ctrl_r[0] <= `RST_CTRL;
            ctrl_r[1] <= `RST_CTRL;
            mask_r    <= 4'h0;
        end else if (wr_en) begin
            case (idx)
                `IDX_GAIN_B:   gain_b_r  <= wb;
                `IDX_DOFS_A:   dofs_r[0] <= wb;
                `IDX_DOFS_B:   dofs_r[1] <= wb;
                `IDX_AOFS_A:   aofs_r[0] <= wb;
                `IDX_AOFS_B:   aofs_r[1] <= wb;
                `IDX_THR_A:    thr_r[0]  <= wb;
                `IDX_THR_B:    thr_r[1]  <= wb;
                `IDX_CTRL_A:   ctrl_r[0] <= wb;
                `IDX_CTRL_B:   ctrl_r[1] <= wb;
                `IDX_IRQ_MASK: mask_r    <= pwdata[3:0];
                default: begin
                    // Read-only or unmapped: no store
                end
            endcase
        end
    end

    // Placement select goes straight to the front end
    // Nothing here depends on it; the analog side does
    assign sense_high_side_a = ctrl_r[0][`CTRL_HIGH_SIDE];
    assign sense_high_side_b = ctrl_r[1][`CTRL_HIGH_SIDE];

    // ------------------------------------------------------------
    // Calibration
    // ------------------------------------------------------------
    // Gain step is 1/1024 of the reading; offsets add in reading
    // steps. The result saturates so a large trim cannot wrap.
    // Order: gain on the raw reading, then analog offset,
    // then the digital offset as a two's complement byte.
    // Sixteen signed bits cover every trim extreme.
    function automatic reading_t calibrate(
        input reading_t   raw,
        input logic [7:0] gain,
        input logic [7:0] dofs,
        input logic [7:0] aofs
    );
        logic [18:0]        prod;
        logic signed [15:0] acc;
        logic signed [15:0] gterm;
        logic signed [15:0] aterm;
        prod  = {7'h00, raw} * {12'h000, gain[6:0]};
        gterm = $signed({7'h00, prod[18:10]});
        aterm = $signed({10'h000, aofs[5:0]});
        acc   = $signed({4'h0, raw});
        if (gain[`GAIN_SIGN_BIT]) begin
            acc = acc - gterm;
        end else begin
            acc = acc + gterm;
        end
        if (aofs[`AOFS_SIGN_BIT]) begin
            acc = acc - aterm;
        end else begin
            acc = acc + aterm;
        end
        acc = acc + $signed({{8{dofs[7]}}, dofs});
        // Clamp to the twelve bit reading range
        if (acc < 16'sh0000) begin
            calibrate = 12'h000;
        end else if (acc > 16'sh0fff) begin
            calibrate = 12'hfff;
        end else begin
            calibrate = acc[11:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Sensed value registers
    // ------------------------------------------------------------
    // Twelve bit reading sits left justified in the 16 bit value
    // Channel A carries no gain trim here, so it runs unity gain
    // Without a valid pulse a value simply holds
    always_comb begin
        value_nxt[0] = value_r[0];
        value_nxt[1] = value_r[1];
        if (adc_valid_a) begin
            value_nxt[0] = {calibrate(adc_raw_a, 8'h00, dofs_r[0], aofs_r[0]), 4'h0};
        end
        if (adc_valid_b) begin
            value_nxt[1] = {calibrate(adc_raw_b, gain_b_r, dofs_r[1], aofs_r[1]), 4'h0};
        end
    end

    // Values reset to zero: no load until a sample arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_r[0] <= 16'h0000;
            value_r[1] <= 16'h0000;
        end else begin
            value_r[0] <= value_nxt[0];
            value_r[1] <= value_nxt[1];
        end
    end

    // ------------------------------------------------------------
    // Per channel compare and light load
    // ------------------------------------------------------------
    // Soft start levels as a vector the loop can index
    logic [1:0] soft_start;
    assign soft_start = {soft_start_b, soft_start_a};

    // One copy per channel; both share one control layout

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        // Working signals of this channel
        logic        ocp_raw;       // Undebounced compare
        deb_cnt_t    cnt_r;         // Debounce progress
        deb_cnt_t    lim;           // Cycles to hold off
        deb_sel_e    dsel;          // Debounce selection
        logic [11:0] rd;            // Current corrected reading
        logic [12:0] ll_enter;      // Entry level
        logic [12:0] ll_exit;       // Exit level
        logic [3:0]  ll_thr;        // Light load code

        // Upper byte of the next value against the threshold;
        // one code is sixteen reading steps, trip at code plus one
        // Using the next value lets the flag move with the write
        assign ocp_raw = (thr_r[ch] != `THR_DISABLED) &&
            (value_nxt[ch][`VALUE_CMP_HI:`VALUE_CMP_LO] > thr_r[ch]);

        assign dsel = deb_sel_e'(ctrl_r[ch][`CTRL_DEB_HI:`CTRL_DEB_LO]);

        // Debounce limit from the control field
        // A zero limit lets the flag follow the compare at once
        // Counts are pclk cycles
        always_comb begin
            case (dsel)
                DEB_NONE:  lim = 27'h0000000;
                DEB_SHORT: lim = DEB1_CYC[26:0];
                DEB_MID:   lim = DEB2_CYC[26:0];
                DEB_LONG:  lim = DEB3_CYC[26:0];
                default:   lim = 27'h0000000;
            endcase
        end

        // Flag rises once the compare has held for the limit; it
        // drops at once, so a noisy sample restarts the wait
        // The counter parks at the limit while the compare holds
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_r     <= 27'h0000000;
                ocp_r[ch] <= 1'b0;
            end else if (!ocp_raw) begin
                cnt_r     <= 27'h0000000;
                ocp_r[ch] <= 1'b0;
            end else if (cnt_r >= lim) begin
                ocp_r[ch] <= 1'b1;
            end else begin
                cnt_r     <= cnt_r + 27'h0000001;
            end
        end

        assign rd       = value_r[ch][15:4];
        assign ll_thr   = ctrl_r[ch][`CTRL_LL_HI:0];
        assign ll_enter = {3'h0, ll_thr, 6'h00};
        assign ll_exit  = ll_enter + `LL_HYST;

        // Light load with hysteresis; between the two levels the
        // flag keeps its last state
        // Entry is the code times 64 steps, exit 96 above; the
        // gap keeps a reading near the edge from chattering.
        // A zero code or soft start blanking wins over both.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ll_r[ch] <= 1'b0;
            end else if (ll_thr == 4'h0) begin
                ll_r[ch] <= 1'b0;
            end else if (ctrl_r[ch][`CTRL_BLANK_BIT] && soft_start[ch]) begin
                ll_r[ch] <= 1'b0;
            end else if ({1'b0, rd} < ll_enter) begin
                ll_r[ch] <= 1'b1;
            end else if ({1'b0, rd} > ll_exit) begin
                ll_r[ch] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Flag outputs
    // ------------------------------------------------------------
    // Straight from the flag registers, no extra delay
    assign chan_a_overcurrent_flag = ocp_r[0];
    assign chan_b_overcurrent_flag = ocp_r[1];
    assign chan_a_light_load_flag  = ll_r[0];
    assign chan_b_light_load_flag  = ll_r[1];

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // A flag that stays up sets its bit only once
    logic [3:0] evt;                // Rising edges of the flags
    logic [3:0] w1c;                // Bits cleared by software
    assign evt = flags_now & ~flags_prev_r;
    // Only a write to the status word clears bits
    assign w1c = (wr_en && (idx == `IDX_IRQ_STATUS)) ? pwdata[3:0] : 4'h0;

    // Set wins over a clear in the same cycle
    // so an event that meets a clear is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_prev_r <= 4'h0;
            status_r     <= 4'h0;
        end else begin
            flags_prev_r <= flags_now;
            status_r     <= (status_r & ~w1c) | evt;
        end
    end

    // Level output, high while an enabled status bit is set
    assign irq = |(status_r & mask_r);

endmodule
`default_nettype wire

// [include/load_current_trim_params.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * load current trim and overcurrent compare block.
 * Assumes a 125 MHz register clock; register index times four is
 * the APB byte address.
 */
`ifndef LOAD_CURRENT_TRIM_PARAMS_SVH
`define LOAD_CURRENT_TRIM_PARAMS_SVH

// Register indexes
`define IDX_GAIN_B       16'hfe13
`define IDX_DOFS_A       16'hfe14
`define IDX_DOFS_B       16'hfe15
`define IDX_AOFS_A       16'hfe16
`define IDX_AOFS_B       16'hfe17
`define IDX_THR_A        16'hfe18
`define IDX_THR_B        16'hfe19
`define IDX_CTRL_A       16'hfe1a
`define IDX_CTRL_B       16'hfe1b
`define IDX_VALUE_A      16'h0010
`define IDX_VALUE_B      16'h0011
`define IDX_FLAGS        16'h0012
`define IDX_IRQ_STATUS   16'h0013
`define IDX_IRQ_MASK     16'h0014

// Field positions
`define GAIN_SIGN_BIT    7
`define AOFS_SIGN_BIT    6
`define CTRL_HIGH_SIDE   7
`define CTRL_DEB_HI      6
`define CTRL_DEB_LO      5
`define CTRL_BLANK_BIT   4
`define CTRL_LL_HI       3
`define VALUE_CMP_HI     15
`define VALUE_CMP_LO     8

// Reset values
`define RST_TRIM         8'h00
`define RST_THR          8'hff
`define RST_CTRL         8'h00
`define THR_DISABLED     8'hff

// Light load scaling in reading steps
`define LL_STEP_SHIFT    6
`define LL_HYST          13'h0060

// Debounce times and clock rate
`define CLK_KHZ          125000
`define DEB1_MS          20
`define DEB2_MS          200
`define DEB3_MS          1000
`define DEB1_CYC         (`DEB1_MS * `CLK_KHZ)
`define DEB2_CYC         (`DEB2_MS * `CLK_KHZ)
`define DEB3_CYC         (`DEB3_MS * `CLK_KHZ)

`endif

// [include/load_current_trim_pkg.sv]
/*
 * Types of the load current trim and overcurrent compare block.
 * Assumes the params header supplies all numeric constants.
 */
package load_current_trim_pkg;
    // Corrected or raw converter reading
    typedef logic [11:0] reading_t;
    // Debounce selection in control bits 6:5
    typedef enum logic [1:0] {
        DEB_NONE,
        DEB_SHORT,
        DEB_MID,
        DEB_LONG
    } deb_sel_e;
    // Debounce counter width fits one second of clocks
    typedef logic [26:0] deb_cnt_t;
endpackage

// [verification/tb_top.sv]
/* Self-checking bench of the trim and overcurrent compare block.
   Assumes params header, package and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "load_current_trim_params.svh"
module tb_top
    import load_current_trim_pkg::*;
();
    // ----------
    // Signals
    // ----------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata;
    logic        av_a, av_b, ss_a, ss_b, ocp_a, ocp_b, ll_a, ll_b, hs_a, hs_b;
    reading_t    raw_a, raw_b;
    logic [32:0] exp_q[$];   // Expected {pslverr, prdata}
    int          n_errors, checked, n, deb;
    logic [7:0]  v[9], t;
    typedef struct {logic [15:0] idx; logic [7:0] v; int c; reading_t r; reading_t e;} trim_case_s;
    trim_case_s  tc[8] = '{'{`IDX_DOFS_A, 8'h08, 0, 100, 108}, '{`IDX_DOFS_A, 8'hf8, 0, 100, 92},
        '{`IDX_DOFS_A, 8'hf8, 0, 3, 0}, '{`IDX_AOFS_A, 8'h45, 0, 100, 95}, '{`IDX_AOFS_A, 8'h85, 0, 100, 105},
        '{`IDX_AOFS_B, 8'h05, 1, 100, 105}, '{`IDX_GAIN_B, 8'h40, 1, 1024, 1088},
        '{`IDX_GAIN_B, 8'hc0, 1, 1024, 960}};
    // Light load steps: control, soft start, reading, flag
    logic [7:0]  lc[8] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h12, 8'h02, 8'h00};
    logic        ls[8] = '{0, 0, 0, 0, 0, 1, 1, 0};
    reading_t    lr[8] = '{128, 127, 224, 225, 127, 127, 127, 0};
    logic        le[8] = '{0, 1, 1, 0, 1, 0, 1, 0};
    // Short debounce counts keep the run brief
    load_current_trim_ocp_compare #(.DEB1_CYC(4), .DEB2_CYC(8), .DEB3_CYC(16)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .adc_valid_a(av_a), .adc_raw_a(raw_a),
        .adc_valid_b(av_b), .adc_raw_b(raw_b), .soft_start_a(ss_a), .soft_start_b(ss_b),
        .chan_a_overcurrent_flag(ocp_a), .chan_b_overcurrent_flag(ocp_b), .chan_a_light_load_flag(ll_a),
        .chan_b_light_load_flag(ll_b), .sense_high_side_a(hs_a), .sense_high_side_b(hs_b), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One APB transfer; its answer is noted in the setup cycle
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge pclk);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0, {1'b0, e});
    endtask
    // One sample, then wait until the light load flag has settled
    task automatic smp(input int c, input reading_t r);
        @(posedge pclk);
        if (c == 0) av_a <= 1'b1;
        else av_b <= 1'b1;
        raw_a <= r;
        raw_b <= r;
        @(posedge pclk);
        av_a <= 1'b0;
        av_b <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic rst();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // Watcher: each completed transfer takes the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (exp_q.size() == 0) chk("apb note", 33'h0, 33'h1);
            else chk("apb answer", {pslverr, prdata}, exp_q.pop_front());
        end
    end
    initial begin
        {psel, penable, pwrite, av_a, av_b, ss_a, ss_b, presetn} = '0;
        {paddr, pwdata, raw_a, raw_b} = '0;
        n_errors = 0;
        checked = 0;
        void'($urandom(32'h55ca));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(`IDX_GAIN_B + 16'(i), (i == 5 || i == 6) ? 32'hff : 32'h0);
        for (int i = 0; i < 9; i++) begin
            v[i] = (i == 5 || i == 6) ? 8'd2 + 8'($urandom_range(239)) : 8'($urandom());
            wr(`IDX_GAIN_B + 16'(i), {24'($urandom()), v[i]});
        end
        for (int i = 0; i < 9; i++) rd(`IDX_GAIN_B + 16'(i), {24'h0, v[i]});
        @(negedge pclk);
        chk("high side a", hs_a, v[7][7]);
        chk("high side b", hs_b, v[8][7]);
        apb(1'b0, 16'h0015, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 16'hfe1c, 32'h5a, {1'b1, 32'h0});
        wr(`IDX_VALUE_A, 32'hffff);
        rd(`IDX_VALUE_A, 32'h0);
        $display("test registers done");
        rst();
        for (int c = 0; c < 2; c++) begin
            t = 8'd2 + 8'($urandom_range(239));
            wr(`IDX_THR_A + 16'(c), {24'h0, t});
            smp(c, {t, 4'hf});
            chk("ocp equal", c ? ocp_b : ocp_a, 1'b0);
            smp(c, {t + 8'd1, 4'h0});
            chk("ocp above", c ? ocp_b : ocp_a, 1'b1);
            rd(`IDX_VALUE_A + 16'(c), {16'h0, t + 8'd1, 8'h00});
            rd(`IDX_FLAGS, 32'h1 << c);
            wr(`IDX_THR_A + 16'(c), 32'hff);
            smp(c, 12'hfff);
            chk("ocp disabled", c ? ocp_b : ocp_a, 1'b0);
        end
        foreach (tc[i]) begin
            wr(tc[i].idx, {24'h0, tc[i].v});
            smp(tc[i].c, tc[i].r);
            rd(`IDX_VALUE_A + 16'(tc[i].c), {16'h0, tc[i].e, 4'h0});
            wr(tc[i].idx, 32'h0);
        end
        $display("test compare and trims done");
        for (int c = 0; c < 2; c++) begin
            smp(c, 12'hfff);   // Start above exit level
            for (int i = 0; i < 8; i++) begin
                wr(`IDX_CTRL_A + 16'(c), {24'h0, lc[i]});
                ss_a <= ls[i];
                ss_b <= ls[i];
                smp(c, lr[i]);
                chk("light load", c ? ll_b : ll_a, le[i]);
            end
        end
        ss_a <= 1'b0;
        ss_b <= 1'b0;
        $display("test light load done");
        rst();
        wr(`IDX_THR_A, 32'd10);
        smp(0, 12'hfff);
        chk("irq masked", irq, 1'b0);
        rd(`IDX_IRQ_STATUS, 32'h1);
        wr(`IDX_IRQ_MASK, 32'h1);
        @(negedge pclk);
        chk("irq unmasked", irq, 1'b1);
        wr(`IDX_IRQ_STATUS, 32'h1);
        rd(`IDX_IRQ_STATUS, 32'h0);
        @(negedge pclk);
        chk("irq cleared", irq, 1'b0);
        $display("test interrupt done");
        for (int d = 1; d < 4; d++) begin
            deb = 2 << d;
            wr(`IDX_CTRL_A, {25'h0, 2'(d), 5'h0});
            smp(0, 12'h000);
            smp(0, 12'hfff);
            n = 0;
            while (ocp_a !== 1'b1 && n < 40) begin
                @(negedge pclk);
                n++;
            end
            chk("debounce span", 33'(n >= deb - 4 && n <= deb), 33'h1);
            if (n >= 40) end_of_test();
        end
        $display("test debounce done");
        end_of_test();
    end
endmodule
`default_nettype wire

// [verification/trim_ocp_props.sv]
/* Checker of the trim and overcurrent compare block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "load_current_trim_params.svh"
module trim_ocp_props (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // Soft start and outputs
    input wire logic        soft_start_a,
    input wire logic        chan_a_overcurrent_flag,
    input wire logic        chan_a_light_load_flag,
    input wire logic        sense_high_side_a,
    input wire logic        sense_high_side_b,
    input wire logic        irq
);
    // ----------
    // Shadow registers
    // ----------
    logic [7:0] thr_r;
    logic [7:0] ctl_r;
    logic [7:0] msk_r;
    wire        wr_ok = psel && penable && pwrite && pready;
    wire        w_ca  = wr_ok && paddr == {14'h0, `IDX_CTRL_A, 2'b00};
    wire        w_cb  = wr_ok && paddr == {14'h0, `IDX_CTRL_B, 2'b00};
    // Follows the access edge, so no lag against the real register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_r <= `RST_THR;
            ctl_r <= `RST_CTRL;
            msk_r <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == {14'h0, `IDX_THR_A, 2'b00}) thr_r <= pwdata[7:0];
            if (w_ca) ctl_r <= pwdata[7:0];
            if (paddr == {14'h0, `IDX_IRQ_MASK, 2'b00}) msk_r <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_const: assert property (pready)
        else $error("pready low");
    chk_rdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata))
        else $error("read data moved outside setup");
    chk_side_a_bit: assert property (w_ca |=> sense_high_side_a == $past(pwdata[7]))
        else $error("high side select a wrong");
    chk_side_b_bit: assert property (w_cb |=> sense_high_side_b == $past(pwdata[7]))
        else $error("high side select b wrong");
    chk_thr_off: assert property (thr_r == 8'hff && $past(thr_r) == 8'hff |-> !chan_a_overcurrent_flag)
        else $error("overcurrent flag set while disabled");
    chk_ll_zero: assert property (ctl_r[3:0] == 4'h0 && $past(ctl_r[3:0]) == 4'h0
        && $past(ctl_r[3:0], 2) == 4'h0 |-> !chan_a_light_load_flag)
        else $error("light load flag set with zero threshold");
    chk_ll_blank: assert property ((ctl_r[4] && soft_start_a) [*3] |-> !chan_a_light_load_flag)
        else $error("light load flag not blanked");
    chk_irq_masked: assert property (msk_r[3:0] == 4'h0 |-> !irq)
        else $error("irq high with all masked");
    cover property ($rose(chan_a_overcurrent_flag));
    cover property ($rose(chan_a_light_load_flag));
    cover property ($rose(irq));
endmodule
bind load_current_trim_ocp_compare trim_ocp_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .soft_start_a(soft_start_a), .chan_a_overcurrent_flag(chan_a_overcurrent_flag),
    .chan_a_light_load_flag(chan_a_light_load_flag), .sense_high_side_a(sense_high_side_a),
    .sense_high_side_b(sense_high_side_b), .irq(irq));
`default_nettype wire
